// ### asc_loader.sv
// Active serial configuration loader with Wishbone register slave
`include "asc_regs.svh"

module asc_loader
    import asc_pkg::*;
#(
    parameter int unsigned UCLK_CYCLES = 8576
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        user_startup_clock,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        config_request_n,
    input  wire logic [3:0]  quad_config_data,
    output logic             config_serial_clock,
    output logic             serial_command_out,
    output logic             flash_select_n,
    output logic             config_complete,
    output logic             init_done_o,
    output logic             init_done_oe,
    output logic             user_mode,
    output logic      [3:0]  config_data,
    output logic             config_data_valid
);

    localparam int UW = $clog2(UCLK_CYCLES + 1);

    generate
        if (UCLK_CYCLES < 2 || UCLK_CYCLES > 65535) begin : g_bad_ucyc
            $error("UCLK_CYCLES out of range");
        end
    endgenerate

    asc_state_type        st_q;
    logic [`ASC_CTRL_W-1:0] ctrl_q;
    logic [31:0]          len_q;
    logic [31:0]          bit_cnt_q;
    logic [31:0]          sreg_q;
    logic [5:0]           cmd_cnt_q;
    logic [4:0]           div_q;
    logic [12:0]          init_cnt_q;
    logic [UW-1:0]        ucnt_q;
    logic                 config_serial_clock_q;
    logic                 ack_q;
    logic                 cc_q;
    logic                 um_q;
    logic                 opt_q;
    logic                 ido_oe_q;
    logic                 uen_q;
    logic                 udone_q;
    logic                 valid_q;
    logic [3:0]           data_q;
    logic [31:0]          dat_q;
    logic                 req_n_s;
    logic [3:0]           qdata_s;
    logic                 udone_s;
    logic                 uen_s;

    // Pins and the user-clock done flag cross into mclk here
    asc_sync #(
        .W(6)
    ) u_pin_sync (
        .clk (mclk),
        .rst (sys_rst),
        .en  (clk_en),
        .d   ({config_request_n, quad_config_data, udone_q}),
        .q   ({req_n_s, qdata_s, udone_s})
    );

    asc_sync #(
        .W(1)
    ) u_usr_sync (
        .clk (user_startup_clock),
        .rst (sys_rst),
        .en  (1'b1),
        .d   (uen_q),
        .q   (uen_s)
    );

    // Control fields
    logic       quad;
    logic [1:0] rate;
    logic [1:0] rate_eff;
    logic       use_uclk;

    assign quad     = ctrl_q[`ASC_CTRL_QUAD];
    assign rate     = ctrl_q[`ASC_CTRL_RATE +: 2];
    assign use_uclk = ctrl_q[`ASC_CTRL_USRCLK];

    assign rate_eff = (ctrl_q[`ASC_CTRL_MULTI] && rate == `ASC_RATE_TOP)
                    ? `ASC_RATE_MULTI : rate;

    // Wishbone slave: one wait state, ack drops the cycle after
    logic wb_req;
    logic wb_wr;

    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wb_wr  = wb_req & wb_we_i;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else if (clk_en) begin
            ack_q <= wb_req;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `ASC_CTRL_RST;
        end else if (clk_en && wb_wr && wb_adr_i == `ASC_REG_CTRL
                     && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[`ASC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            len_q <= `ASC_LEN_MIN;
        end else if (clk_en && wb_wr && wb_adr_i == `ASC_REG_LEN) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    len_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dat_q <= 32'h00000000;
        end else if (clk_en && wb_req) begin
            unique case (wb_adr_i)
                `ASC_REG_CTRL: dat_q <= {27'h0000000, ctrl_q};
                `ASC_REG_LEN:  dat_q <= len_q;
                `ASC_REG_STAT: dat_q <= {24'h000000, config_serial_clock_q, opt_q,
                                         st_q == ST_ERR, um_q, cc_q,
                                         3'(st_q)};
                `ASC_REG_CNT:  dat_q <= bit_cnt_q;
                default:       dat_q <= 32'h00000000;
            endcase
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;

    // Serial clock generation from mclk
    logic       running;
    logic       tick;
    logic       fall;
    logic [4:0] half;

    assign running = (st_q == ST_CMD) || (st_q == ST_DATA);
    // four dividers, halving the period per step
    assign half    = `ASC_HALF_SLOW >> rate_eff;
    assign tick    = running && div_q == 5'h00;
    assign fall    = tick && config_serial_clock_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q  <= 5'h00;
            config_serial_clock_q <= 1'b0;
        end else if (clk_en) begin
            if (!running) begin
                div_q  <= 5'h00;
                config_serial_clock_q <= 1'b0;
            end else if (tick) begin
                div_q  <= half - 5'h01;
                config_serial_clock_q <= ~config_serial_clock_q;
            end else begin
                div_q <= div_q - 5'h01;
            end
        end
    end

    // Length check and bit counting
    logic        len_ok;
    logic [2:0]  step;
    logic [32:0] bit_sum;
    logic        done_now;
    logic [3:0]  sample;
    logic        cmd_last;
    logic        idle_go;
    logic        init_fin;

    assign len_ok = len_q >= `ASC_LEN_MIN && len_q <= `ASC_LEN_MAX;

    // four bits per clock; one bit per clock
    assign step   = quad ? 3'h4 : 3'h1;
    assign sample = quad ? qdata_s : {3'b000, qdata_s[1]};

    assign bit_sum  = {1'b0, bit_cnt_q} + {30'h00000000, step};
    // complete only when the full stream has arrived
    assign done_now = fall && st_q == ST_DATA && bit_sum >= {1'b0, len_q};
    assign cmd_last = cmd_cnt_q == (quad ? `ASC_CMD_BITS + `ASC_DUMMY_QUAD
                                          - 6'h01
                                         : `ASC_CMD_BITS - 6'h01);
    assign idle_go  = st_q == ST_IDLE && req_n_s && len_ok;

    // internal clock waits the least time; user clock count
    assign init_fin = use_uclk ? udone_s
                    : init_cnt_q == 13'(`ASC_CD2UM_CYC - 1);

    // Main sequence
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
        end else if (clk_en) begin
            // a low request always aborts to idle
            if (!req_n_s) begin
                st_q <= ST_IDLE;
            end else begin
                unique case (st_q)
                    ST_IDLE: st_q <= len_ok ? ST_CMD : ST_ERR;
                    ST_CMD:  if (fall && cmd_last) begin
                        st_q <= ST_DATA;
                    end
                    ST_DATA: if (done_now) begin
                        st_q <= ST_INIT;
                    end
                    ST_INIT: if (init_fin) begin
                        st_q <= ST_USER;
                    end
                    ST_USER: st_q <= ST_USER;
                    ST_ERR:  st_q <= ST_ERR;
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // Command shifter: read opcode then a zero address
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sreg_q    <= 32'h00000000;
            cmd_cnt_q <= 6'h00;
        end else if (clk_en) begin
            if (idle_go) begin
                sreg_q    <= {quad ? `ASC_CMD_QUAD : `ASC_CMD_SINGLE,
                              24'h000000};
                cmd_cnt_q <= 6'h00;
            // next command bit after the fall
            end else if (fall && st_q == ST_CMD) begin
                sreg_q    <= {sreg_q[30:0], 1'b0};
                cmd_cnt_q <= cmd_cnt_q + 6'h01;
            end
        end
    end

    // Data capture
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_q <= 32'h00000000;
            data_q    <= 4'h0;
            valid_q   <= 1'b0;
            opt_q     <= 1'b0;
        end else if (clk_en) begin
            valid_q <= 1'b0;
            if (idle_go) begin
                bit_cnt_q <= 32'h00000000;
                opt_q     <= 1'b0;
            end else if (fall && st_q == ST_DATA) begin
                data_q    <= sample;
                valid_q   <= 1'b1;
                bit_cnt_q <= bit_sum[31:0];
                if (bit_cnt_q == 32'h00000000) begin
                    opt_q <= sample[0];
                end
            end
        end
    end

    // hold off the user clock, then hand over
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            init_cnt_q <= 13'h0000;
            uen_q      <= 1'b0;
        end else if (clk_en) begin
            if (st_q != ST_INIT) begin
                init_cnt_q <= 13'h0000;
                uen_q      <= 1'b0;
            end else begin
                if (!init_fin) begin
                    init_cnt_q <= init_cnt_q + 13'h0001;
                end
                if (use_uclk
                    && init_cnt_q == 13'(`ASC_CD2CU_CYC - 1)) begin
                    uen_q <= 1'b1;
                end
            end
        end
    end

    // count user clock cycles in their own domain
    always_ff @(posedge user_startup_clock or posedge sys_rst) begin
        if (sys_rst) begin
            ucnt_q  <= '0;
            udone_q <= 1'b0;
        end else if (!uen_s) begin
            ucnt_q  <= '0;
            udone_q <= 1'b0;
        end else if (ucnt_q == UW'(UCLK_CYCLES - 1)) begin
            udone_q <= 1'b1;
        end else begin
            ucnt_q <= ucnt_q + UW'(1);
        end
    end

    // Pin-facing status flops
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cc_q     <= 1'b0;
            um_q     <= 1'b0;
            ido_oe_q <= 1'b0;
        end else if (clk_en) begin
            // low until the stream is complete
            cc_q     <= req_n_s && (done_now || st_q == ST_INIT
                                    || st_q == ST_USER);
            um_q     <= req_n_s && (st_q == ST_USER
                                    || (st_q == ST_INIT && init_fin));
            // pull init-done low while option set, outside idle and user mode
            ido_oe_q <= opt_q && st_q != ST_USER && st_q != ST_IDLE;
        end
    end

    assign config_serial_clock = config_serial_clock_q;
    // output changes only at the fall, or at the opcode load in idle
    assign serial_command_out  = sreg_q[31];
    assign flash_select_n      = ~running;
    assign config_complete     = cc_q;
    assign user_mode           = um_q;
    assign init_done_o         = 1'b0;
    assign init_done_oe        = ido_oe_q;
    assign config_data         = data_q;
    assign config_data_valid   = valid_q;

endmodule

// ### asc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

`define ASC_REG_CTRL     4'h0
`define ASC_REG_LEN      4'h4
`define ASC_REG_STAT     4'h8
`define ASC_REG_CNT      4'hC

`define ASC_CTRL_QUAD    0
`define ASC_CTRL_RATE    1
`define ASC_CTRL_MULTI   3
`define ASC_CTRL_USRCLK  4
`define ASC_CTRL_W       5
`define ASC_CTRL_RST     5'h00

`define ASC_LEN_MIN      32'h083397A0
`define ASC_LEN_MAX      32'h146DD7C0

`define ASC_RATE_TOP     2'h3
`define ASC_RATE_MULTI   2'h2
`define ASC_HALF_SLOW    5'h10

`define ASC_CMD_SINGLE   8'h03
`define ASC_CMD_QUAD     8'h6B
`define ASC_CMD_BITS     6'h20
`define ASC_DUMMY_QUAD   6'h08

`define ASC_MCLK_KHZ     20000
`define ASC_SLOW_KHZ     12500
`define ASC_CD2CU_NS     (4 * 1000000 / `ASC_SLOW_KHZ)
`define ASC_CD2CU_CYC    ((`ASC_CD2CU_NS * `ASC_MCLK_KHZ + 999999) / 1000000)
`define ASC_CD2UM_US     175
`define ASC_CD2UM_CYC    ((`ASC_CD2UM_US * `ASC_MCLK_KHZ + 999) / 1000)

`endif

// ### asc_pkg.sv
// Types shared by the active serial configuration loader
package asc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD  = 3'h1,
        ST_DATA = 3'h3,
        ST_INIT = 3'h2,
        ST_USER = 3'h6,
        ST_ERR  = 3'h4
    } asc_state_type;

endpackage

// ### asc_sync.sv
// Two-flop level synchroniser, one lane per bit
module asc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else if (en) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ### asc_flash_model.sv
// Behavioural serial configuration flash streaming nibbles
module asc_flash_model (
    input  logic       config_serial_clock,
    input  logic       flash_select_n,
    output logic [3:0] quad_config_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial quad_config_data = 4'h5;

    // launch on rise
    // A fresh nibble each rise keeps it steady across the fall
    always @(posedge config_serial_clock or posedge flash_select_n) begin
        if (flash_select_n)
            quad_config_data <= ~quad_config_data;
        else
            quad_config_data <= quad_config_data + 4'h3;
    end
endmodule

// ### asc_loader_asserts.sv
// Port checker for the configuration loader
module asc_loader_asserts #(
    parameter int unsigned UCLK_CYCLES = 8576
) (
    input logic        mclk,
    input logic        sys_rst,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [3:0]  wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        config_request_n,
    input logic        config_serial_clock,
    input logic        serial_command_out,
    input logic        flash_select_n,
    input logic        config_complete,
    input logic        user_mode,
    input logic        config_data_valid
);
    logic [4:0] half_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Cycles since the serial clock last toggled
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            half_q <= 5'h00;
        else if ($changed(config_serial_clock))
            half_q <= 5'h01;
        else
            half_q <= half_q + 5'h01;
    end

    half_period_a: assert property (
        $fell(config_serial_clock) && !flash_select_n
        |-> half_q inside {5'h02, 5'h04, 5'h08, 5'h10})
        else $error("serial clock half period off");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_reply_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
        && !wb_ack_o && wb_adr_i[1:0] != 2'h0 |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    cmd_on_fall_a: assert property (
        $changed(serial_command_out) && !flash_select_n
        && !$past(flash_select_n) |-> $fell(config_serial_clock))
        else $error("command bit moved off the fall");
    sample_on_low_a: assert property (
        config_data_valid |-> $fell(config_serial_clock))
        else $error("data sample not at the fall");
    done_low_a: assert property (
        !flash_select_n |-> !config_complete)
        else $error("complete high while loading");
    done_then_init_a: assert property (
        $rose(config_complete) |-> flash_select_n && !config_serial_clock)
        else $error("complete without stopping the link");
    user_after_done_a: assert property (
        user_mode |-> config_complete)
        else $error("user mode before completion");
    abort_idle_a: assert property (
        !config_request_n [*5] |-> flash_select_n && !config_serial_clock)
        else $error("request low did not stop loading");

    cover property (!flash_select_n ##1 flash_select_n);
    cover property ($fell(config_serial_clock) && half_q == 5'h10);
    cover property (config_data_valid);
endmodule

bind asc_loader asc_loader_asserts #(.UCLK_CYCLES(UCLK_CYCLES))
    u_asc_loader_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .config_request_n(config_request_n),
    .config_serial_clock(config_serial_clock),
    .serial_command_out(serial_command_out),
    .flash_select_n(flash_select_n), .config_complete(config_complete),
    .user_mode(user_mode), .config_data_valid(config_data_valid));

// ### tb_active_serial_config_loader.sv
// Self-checking bench for the active serial configuration loader
`include "asc_regs.svh"
module tb_active_serial_config_loader;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk = 0, sys_rst = 1, uclk = 0, req_n = 0;
    logic        cyc = 0, stb = 0, we = 0, ack, sclk, cmd, fsel_n;
    logic        done, umode, vld, ido, idoe;
    logic [3:0]  adr = 4'h0, sel = 4'h0, qd, cdat;
    logic [31:0] wdat = 32'h0, rdat, q;
    int          errors = 0, n_tests = 0, nf = 0, k;
    logic [31:0] bad [2] = '{32'h0833979F, 32'h146DD7C1};
    logic [4:0]  ctl [6] = '{5'h01, 5'h02, 5'h04, 5'h16, 5'h07, 5'h0F};
    logic [7:0]  opc [6] = '{8'h6B, 8'h03, 8'h03, 8'h03, 8'h6B, 8'h6B};
    logic [31:0] hp [6]  = '{16, 8, 4, 2, 2, 4};

    always #25 mclk = ~mclk;
    always #24 uclk = ~uclk;
    always @(negedge sclk or posedge fsel_n) nf <= fsel_n ? 0 : nf + 1;

    asc_loader #(.UCLK_CYCLES(16)) u_asc_loader (.mclk(mclk),
        .sys_rst(sys_rst), .clk_en(1'b1), .user_startup_clock(uclk),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .config_request_n(req_n), .quad_config_data(qd),
        .config_serial_clock(sclk), .serial_command_out(cmd),
        .flash_select_n(fsel_n), .config_complete(done),
        .init_done_o(ido), .init_done_oe(idoe), .user_mode(umode),
        .config_data(cdat), .config_data_valid(vld));
    asc_flash_model u_asc_flash_model (.config_serial_clock(sclk),
        .flash_select_n(fsel_n), .quad_config_data(qd));

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, s,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 20)
            errors++;
    endtask

    task automatic rd(input string nm, input logic [3:0] a,
                      input logic [31:0] e);
        bus(1'b0, a, 4'hF, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic run(input int i);
        logic [31:0] s;
        time         t;
        bus(1'b1, `ASC_REG_CTRL, 4'h1, {27'h0, ctl[i]});
        req_n <= 1'b1;
        for (int b = 0; b < 32; b++) begin
            @(posedge sclk);
            s = {s[30:0], cmd};
            if (b == 0) begin
                t = $time;
                @(negedge sclk);
                chk("half period", hp[i] * 50, 32'($time - t));
            end
        end
        chk("command", {opc[i], 24'h0}, s);
    endtask

    task automatic conclude;
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Full run needs well under a quarter of this span
    initial begin
        #1_000_000;
        errors++;
        conclude();
    end

    // Full streams are far too long to finish here, so init stays unseen
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd("ctrl", `ASC_REG_CTRL, 32'h0);
        rd("length", `ASC_REG_LEN, `ASC_LEN_MIN);
        rd("status", `ASC_REG_STAT, 32'h0);
        rd("count", `ASC_REG_CNT, 32'h0);
        rd("unmapped", 4'h2, 32'h0);
        bus(1'b1, `ASC_REG_STAT, 4'hF, 32'hFF);
        bus(1'b1, `ASC_REG_CTRL, 4'hE, 32'h1F);
        rd("status ro", `ASC_REG_STAT, 32'h0);
        rd("ctrl sel", `ASC_REG_CTRL, 32'h0);
        foreach (bad[i]) begin
            bus(1'b1, `ASC_REG_LEN, 4'hF, bad[i]);
            req_n <= 1'b1;
            repeat (8) @(posedge mclk);
            rd("error state", `ASC_REG_STAT, 32'h24);
            chk("clock idle", 32'h0, {31'h0, sclk});
            req_n <= 1'b0;
        end
        bus(1'b1, `ASC_REG_LEN, 4'hF, `ASC_LEN_MAX);
        foreach (ctl[i]) begin
            req_n <= 1'b0;
            repeat (6) @(posedge mclk);
            chk("abort", 32'h1, {30'h0, sclk, fsel_n});
            run(i);
        end
        repeat (200) @(posedge mclk);
        @(negedge sclk);
        // Let the fall counter settle before reading it
        @(posedge mclk);
        k = nf;
        bus(1'b0, `ASC_REG_CNT, 4'hF, 32'h0);
        chk("bit count", 32'(4 * (k - 40)), q);
        bus(1'b0, `ASC_REG_STAT, 4'hF, 32'h0);
        chk("loading", 32'h03, q & 32'h3F);
        chk("complete", 32'h0, {31'h0, done});
        req_n <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("abort", 32'h1, {30'h0, sclk, fsel_n});
        conclude();
    end
endmodule
